// ### hdl/abcc_pkg.sv
// Package of constants and types for the adaptive backlight and chroma command block.
// Assumes a byte-wide command stream already deserialised by the serial interface.
package abcc_pkg;

   localparam logic [7:0] ABCC_CMD_WRITE_MODE  = 8'h55;
   localparam logic [7:0] ABCC_CMD_READ_MODE   = 8'h56;
   localparam logic [7:0] ABCC_CMD_WRITE_MINBR = 8'h5e;
   localparam logic [7:0] ABCC_CMD_READ_MINBR  = 8'h5f;
   localparam logic [7:0] ABCC_CMD_READ_BWLOW  = 8'h70;

   localparam logic [1:0]  ABCC_MODE_RESET   = 2'h0;
   localparam logic [15:0] ABCC_MINBR_RESET  = 16'h0000;
   localparam logic [7:0]  ABCC_BWLOW_RESET  = 8'h00;
   localparam logic [5:0]  ABCC_MODE_PAD     = 6'h00;

   localparam int ABCC_BKX_POS = 6;
   localparam int ABCC_BKY_POS = 4;
   localparam int ABCC_WX_POS  = 2;
   localparam int ABCC_WY_POS  = 0;

   typedef enum logic [1:0] {
      ABCC_MODE_OFF,
      ABCC_MODE_UI,
      ABCC_MODE_STILL,
      ABCC_MODE_MOVING
   } abcc_mode_t;

   typedef struct packed {
      logic [1:0] black_x;
      logic [1:0] black_y;
      logic [1:0] white_x_coord;
      logic [1:0] white_y_coord;
   } abcc_chroma_low_t;

   typedef struct packed {
      logic [7:0] min_brightness_first;
      logic [7:0] min_brightness_second;
   } abcc_minbr_t;

endpackage

// ### hdl/abcc_sync_reg.sv
// Holding register for the adaptive mode, updated only on a frame boundary.
// Assumes vsync_pulse is a one-cycle pulse on clk_sys.
`timescale 1ns/1ps
module abcc_sync_reg
   import abcc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Pending value and frame strobe
   input  wire abcc_mode_t pending_mode,
   input  wire logic       vsync_pulse,
   // Active value
   output abcc_mode_t      active_mode
);

   abcc_mode_t active_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         active_q <= abcc_mode_t'(ABCC_MODE_RESET);
      end else if (vsync_pulse) begin
         active_q <= pending_mode;
      end
   end

   assign active_mode = active_q;

endmodule

// ### hdl/abcc_cmd.sv
// Command interpreter for adaptive backlight settings and black/white low bits.
// Assumes a front end that hands over command and parameter bytes with strobes,
// and that pulls read parameter bytes with a request strobe, all on clk_sys.
`timescale 1ns/1ps
module abcc_cmd
   import abcc_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // Command byte stream from the serial interface
   input  wire logic             cmd_valid,
   input  wire logic [7:0]       cmd_byte,
   input  wire logic             param_valid,
   input  wire logic [7:0]       param_byte,
   // Read parameter pull
   input  wire logic             rd_req,
   output logic                  rd_valid,
   output logic [7:0]            rd_data,
   // Frame timing pin and one-time memory contents
   input  wire logic             vsync_pin,
   input  wire logic             otp_programmed,
   input  wire abcc_chroma_low_t otp_chroma_low,
   // Settings towards the backlight logic
   output abcc_mode_t            adaptive_mode,
   output abcc_minbr_t           min_brightness
);

   // ----------------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------------
   logic       rst_s1_q;
   logic       rst_s2_q;
   logic       rst_l;
   logic [2:0] vs_q;
   logic       vsync_rise;

   // Reset leaves through two stages so every flop on rst_l sees a clean release.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_l = rst_s2_q;

   always_ff @(posedge clk_sys or negedge rst_l) begin
      if (!rst_l) begin
         vs_q <= 3'h0;
      end else begin
         vs_q <= {vs_q[1:0], vsync_pin};
      end
   end
   // Only the second stage feeds logic; the third just remembers it for the edge.
   assign vsync_rise = vs_q[1] & ~vs_q[2];

   // ----------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ABCC_ST_IDLE,
      ABCC_ST_WMODE,
      ABCC_ST_WMB1,
      ABCC_ST_WMB2,
      ABCC_ST_RD1,
      ABCC_ST_RD2
   } abcc_state_t;

   abcc_state_t state_q;
   abcc_state_t state_d;
   abcc_mode_t  pend_mode_q;
   abcc_minbr_t minbr_q;
   logic [7:0]  first_q;
   logic [7:0]  rd_first_q;
   logic [7:0]  rd_second_q;
   logic [7:0]  rd_data_q;
   logic        rd_valid_q;

   wire is_wmode = cmd_byte == ABCC_CMD_WRITE_MODE;
   wire is_rmode = cmd_byte == ABCC_CMD_READ_MODE;
   wire is_wmb   = cmd_byte == ABCC_CMD_WRITE_MINBR;
   wire is_rmb   = cmd_byte == ABCC_CMD_READ_MINBR;
   wire is_rbw   = cmd_byte == ABCC_CMD_READ_BWLOW;

   // Low bits read as zero until the one-time memory holds a value.
   wire abcc_chroma_low_t chroma_low = otp_programmed ? otp_chroma_low : abcc_chroma_low_t'(ABCC_BWLOW_RESET);

   wire [7:0] mode_byte = {ABCC_MODE_PAD, adaptive_mode};
   wire [7:0] bw_byte   = {chroma_low.black_x, chroma_low.black_y,
                           chroma_low.white_x_coord, chroma_low.white_y_coord};

   // ----------------------------------------------------------------------
   // Write and read strobes
   // ----------------------------------------------------------------------
   // A command byte always wins, so a new command aborts a half-finished write.
   wire       param_take  = param_valid && !cmd_valid;
   wire       take_mode   = param_take && state_q == ABCC_ST_WMODE;
   wire       take_first  = param_take && state_q == ABCC_ST_WMB1;
   wire       take_second = param_take && state_q == ABCC_ST_WMB2;
   wire       rd_take_1   = rd_req && !cmd_valid && state_q == ABCC_ST_RD1;
   wire       rd_take_2   = rd_req && !cmd_valid && state_q == ABCC_ST_RD2;
   wire       rd_take     = rd_take_1 || rd_take_2;
   // Read bytes are frozen when the command is taken, so a later write cannot tear them.
   wire [7:0] snap_single = is_rmode ? mode_byte : bw_byte;
   wire [7:0] snap_second = is_rmb ? minbr_q.min_brightness_second : snap_single;
   wire [7:0] rd_next     = rd_take_1 ? rd_first_q : rd_second_q;

   // No power state enters the decode, so all five command codes are served at all times.
   // Unknown command codes fall back to idle and are otherwise ignored.
   always_comb begin
      state_d = state_q;
      if (cmd_valid) begin
         if (is_wmode) begin
            state_d = ABCC_ST_WMODE;
         end else if (is_wmb) begin
            state_d = ABCC_ST_WMB1;
         end else if (is_rmode || is_rbw) begin
            state_d = ABCC_ST_RD2;
         end else if (is_rmb) begin
            state_d = ABCC_ST_RD1;
         end else begin
            state_d = ABCC_ST_IDLE;
         end
      end else begin
         case (state_q)
            ABCC_ST_WMODE: begin
               if (param_valid) begin
                  state_d = ABCC_ST_IDLE;
               end
            end
            ABCC_ST_WMB1: begin
               if (param_valid) begin
                  state_d = ABCC_ST_WMB2;
               end
            end
            ABCC_ST_WMB2: begin
               if (param_valid) begin
                  state_d = ABCC_ST_IDLE;
               end
            end
            ABCC_ST_RD1: begin
               if (rd_req) begin
                  state_d = ABCC_ST_RD2;
               end
            end
            ABCC_ST_RD2: begin
               if (rd_req) begin
                  state_d = ABCC_ST_IDLE;
               end
            end
            default: begin
               state_d = ABCC_ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_l) begin
      if (!rst_l) begin
         state_q     <= ABCC_ST_IDLE;
         pend_mode_q <= abcc_mode_t'(ABCC_MODE_RESET);
         minbr_q     <= abcc_minbr_t'(ABCC_MINBR_RESET);
         first_q     <= 8'h00;
         rd_first_q  <= 8'h00;
         rd_second_q <= 8'h00;
      end else begin
         state_q <= state_d;
         if (take_mode) begin
            pend_mode_q <= abcc_mode_t'(param_byte[1:0]);
         end
         // The first byte waits here, so a cut write leaves the stored pair whole.
         if (take_first) begin
            first_q <= param_byte;
         end
         if (take_second) begin
            minbr_q <= '{min_brightness_first: first_q, min_brightness_second: param_byte};
         end
         if (cmd_valid) begin
            rd_first_q  <= minbr_q.min_brightness_first;
            rd_second_q <= snap_second;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read answer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_l) begin
      if (!rst_l) begin
         rd_valid_q <= 1'b0;
         rd_data_q  <= 8'h00;
      end else begin
         rd_valid_q <= rd_take;
         // The last read byte stays on rd_data until the next accepted pull.
         if (rd_take) begin
            rd_data_q <= rd_next;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Outputs and frame-synchronised mode
   // ----------------------------------------------------------------------

   assign rd_valid       = rd_valid_q;
   assign rd_data        = rd_data_q;
   assign min_brightness = minbr_q;

   abcc_sync_reg u_mode (
      .clk_sys      (clk_sys),
      .rst_n        (rst_l),
      .pending_mode (pend_mode_q),
      .vsync_pulse  (vsync_rise),
      .active_mode  (adaptive_mode)
   );

endmodule

// ### verification/abcc_host.sv
// Host model that sends command and parameter bytes and pulls read bytes.
// Assumes the bench clock; every strobe changes just after a rising edge.
`timescale 1ns/1ps
module abcc_host (
   // Clock
   input  wire logic  clk_sys,
   // Command stream towards the block
   output logic       cmd_valid,
   output logic [7:0] cmd_byte,
   output logic       param_valid,
   output logic [7:0] param_byte,
   output logic       rd_req
);
   initial begin
      {cmd_valid, param_valid, rd_req} = 3'h0;
      {cmd_byte, param_byte} = 16'h0000;
   end
   // Released bytes show their inverse so stale data cannot pass.
   task automatic send(input logic is_cmd, input logic [7:0] b);
      @(posedge clk_sys);
      cmd_valid <= is_cmd;
      param_valid <= !is_cmd;
      {cmd_byte, param_byte} <= {b, b};
      @(posedge clk_sys);
      {cmd_valid, param_valid} <= 2'h0;
      {cmd_byte, param_byte} <= ~{b, b};
   endtask
   task automatic pull();
      @(posedge clk_sys);
      rd_req <= 1'b1;
      @(posedge clk_sys);
      rd_req <= 1'b0;
   endtask
endmodule

// ### verification/abcc_cmd_chk.sv
// Checker for the command block, bound to abcc_cmd.
// Assumes a read pull comes one to three cycles after its command.
`timescale 1ns/1ps
module abcc_cmd_chk
   import abcc_pkg::*;
(
   // Clock, reset and command stream
   input wire logic             clk_sys,
   input wire logic             rst_n,
   input wire logic             cmd_valid,
   input wire logic [7:0]       cmd_byte,
   input wire logic             param_valid,
   input wire logic [7:0]       param_byte,
   input wire logic             rd_req,
   input wire logic             rd_valid,
   input wire logic [7:0]       rd_data,
   // Frame, memory and settings
   input wire logic             vsync_pin,
   input wire logic             otp_programmed,
   input wire abcc_chroma_low_t otp_chroma_low,
   input wire abcc_mode_t       adaptive_mode,
   input wire abcc_minbr_t      min_brightness
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   rst_zero_a: assert property ($rose(rst_n) |-> ##2 adaptive_mode == 2'h0 && min_brightness == 16'h0 && !rd_valid)
      else $error("settings not zero after reset");
   rd_cause_a: assert property (rd_valid |-> $past(rd_req))
      else $error("read answer without pull");
   br_cause_a: assert property ($changed(min_brightness) |-> $past(param_valid))
      else $error("brightness moved without parameter");
   br_low_a: assert property ($changed(min_brightness) |-> min_brightness[7:0] == $past(param_byte))
      else $error("second byte not stored low");
   mode_sync_a: assert property ($changed(adaptive_mode) |-> $past(vsync_pin, 3))
      else $error("mode changed off frame boundary");
   mode_rd_a: assert property (
      cmd_valid && cmd_byte == 8'h56 ##[1:3] rd_req |=> rd_data == {6'h00, adaptive_mode})
      else $error("mode readback wrong");
   br_rd_a: assert property (
      cmd_valid && cmd_byte == 8'h5f ##[1:3] rd_req |=> rd_data == min_brightness[15:8])
      else $error("brightness readback wrong");
   bw_rd_a: assert property (
      cmd_valid && cmd_byte == 8'h70 ##[1:3] rd_req |=> rd_data == (otp_programmed ? 8'(otp_chroma_low) : 8'h00))
      else $error("low bits readback wrong");
endmodule
bind abcc_cmd abcc_cmd_chk u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
   .param_valid(param_valid), .param_byte(param_byte), .rd_req(rd_req), .rd_valid(rd_valid),
   .rd_data(rd_data), .vsync_pin(vsync_pin), .otp_programmed(otp_programmed),
   .otp_chroma_low(otp_chroma_low), .adaptive_mode(adaptive_mode), .min_brightness(min_brightness)
);

// ### verification/adaptive_backlight_chroma_cmds_tb_top.sv
// Self-checking bench for the adaptive backlight command block.
// Assumes abcc_host drives the command stream; the bench drives frame and memory pins.
`timescale 1ns/1ps
module adaptive_backlight_chroma_cmds_tb_top
   import abcc_pkg::*;
();
   logic             clk_sys = 1'b0;
   logic             rst_n = 1'b0;
   logic             vsync_pin = 1'b0;
   logic             otp_programmed = 1'b0;
   abcc_chroma_low_t otp_chroma_low = 8'hff;
   logic             cmd_valid, param_valid, rd_req, rd_valid;
   logic [7:0]       cmd_byte, param_byte, rd_data;
   abcc_mode_t       adaptive_mode;
   abcc_minbr_t      min_brightness;
   int               n_mismatch = 0;
   int               n_checks = 0;
   int               cycles = 0;
   always #5 clk_sys = ~clk_sys;
   abcc_host host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
      .param_valid(param_valid), .param_byte(param_byte), .rd_req(rd_req));
   abcc_cmd uut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
      .param_valid(param_valid), .param_byte(param_byte), .rd_req(rd_req), .rd_valid(rd_valid),
      .rd_data(rd_data), .vsync_pin(vsync_pin), .otp_programmed(otp_programmed),
      .otp_chroma_low(otp_chroma_low), .adaptive_mode(adaptive_mode), .min_brightness(min_brightness));
   task automatic end_sim();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // One pull; the answer must stand one cycle later with the byte.
   task automatic rd(input logic [7:0] exp);
      host.pull();
      #1;
      chk({7'h00, rd_valid, rd_data}, {8'h01, exp});
   endtask
   task automatic bw_case(input logic prog, input logic [7:0] v, input logic [7:0] exp);
      @(posedge clk_sys);
      otp_programmed <= prog;
      otp_chroma_low <= v;
      host.send(1'b1, ABCC_CMD_READ_BWLOW);
      rd(exp);
   endtask
   task automatic do_reset();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk_sys);
      #1;
      chk(16'(adaptive_mode), 16'h0000);
      chk(min_brightness, ABCC_MINBR_RESET);
      bw_case(1'b0, 8'hff, 8'h00);
      host.send(1'b1, ABCC_CMD_READ_MINBR);
      rd(8'h00);
      rd(8'h00);
   endtask
   task automatic mode_case(input abcc_mode_t m, input abcc_mode_t prev);
      host.send(1'b1, ABCC_CMD_WRITE_MODE);
      host.send(1'b0, {ABCC_MODE_PAD, m});
      repeat (8) @(posedge clk_sys);
      chk(16'(adaptive_mode), 16'(prev));
      vsync_pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      vsync_pin <= 1'b0;
      #1;
      chk(16'(adaptive_mode), 16'(m));
      host.send(1'b1, ABCC_CMD_READ_MODE);
      rd({ABCC_MODE_PAD, m});
   endtask
   // A half write cut short by a new command must leave the stored pair alone.
   task automatic minbr_case(input logic [7:0] a, input logic [7:0] b);
      host.send(1'b1, ABCC_CMD_WRITE_MINBR);
      host.send(1'b0, a);
      host.send(1'b0, b);
      @(posedge clk_sys);
      #1;
      chk(min_brightness, {a, b});
      host.send(1'b1, ABCC_CMD_READ_MINBR);
      rd(a);
      rd(b);
      host.send(1'b1, ABCC_CMD_WRITE_MINBR);
      host.send(1'b0, ~a);
      host.send(1'b1, ABCC_CMD_READ_MINBR);
      rd(a);
   endtask
   initial begin
      do_reset();
      for (int i = 1; i < 5; i++) begin
         mode_case(abcc_mode_t'(2'(i)), abcc_mode_t'(2'(i - 1)));
      end
      minbr_case(8'h00, 8'hff);
      minbr_case(8'hff, 8'h00);
      bw_case(1'b1, 8'h1b, 8'h1b);
      bw_case(1'b1, 8'he4, 8'he4);
      mode_case(ABCC_MODE_STILL, ABCC_MODE_OFF);
      do_reset();
      end_sim();
   end
endmodule
